/* hdl/adc_code_to_temperature.sv */
// conversion code to rtd resistance and table-interpolated temperature
`timescale 1ns/1ns
// How it works
// - one step weighs full-scale range over two to the 24; voltage is step times code
// - full-scale range is two times reference over gain
// - gain comes from the three-bit gain selection configuration input
// - resistance equals two times reference resistor times code over gain times 2^24
// - reference resistor 3900 ohms, gains 1, 2 or 4 supported
// - scan table until an entry exceeds code, keep last index not exceeding
// - retained index is the integer temperature, one degree per entry
// - fraction is linear interpolation between entries n and n+1
// - with both address straps low the serial target address is 1000101
module adc_code_to_temperature #(
  parameter int TBL_DEPTH = rtd_conv_pkg::TBL_DEPTH_DFLT,
  parameter int IDX_W = $clog2(rtd_conv_pkg::TBL_DEPTH_DFLT),
  parameter int RREF_OHM = rtd_conv_pkg::RREF_OHM_DFLT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // conversion code stream
  input wire logic code_valid_i,
  input wire logic [rtd_conv_pkg::CODE_W-1:0] code_i,
  output logic code_ready_o,
  // configuration
  input wire logic [rtd_conv_pkg::GAIN_SEL_W-1:0] gain_sel_i,
  input wire logic address_strap_a_i,
  input wire logic address_strap_b_i,
  // table load port
  input wire logic tbl_wr_i,
  input wire logic [IDX_W-1:0] tbl_wr_addr_i,
  input wire logic [rtd_conv_pkg::CODE_W-1:0] tbl_wr_data_i,
  // results
  output logic res_valid_o,
  output logic [rtd_conv_pkg::RES_W-1:0] res_o,
  output logic temp_valid_o,
  output logic [IDX_W-1:0] temp_int_o,
  output logic [rtd_conv_pkg::TEMP_FRAC_W-1:0] temp_frac_o,
  output logic out_of_range_o,
  output logic gain_err_o,
  output logic busy_o,
  output logic [6:0] target_addr_o
);
  import rtd_conv_pkg::*;

  localparam int BIT_W = $clog2(TEMP_FRAC_W) + 1;
  localparam int DIF_W = CODE_W + 2;
  localparam logic signed [PROD_W-1:0] RREF_K = PROD_W'(SCALE_M * RREF_OHM);
  localparam int RES_SHIFT = LSB_EXP - RES_FRAC_W;

  table_if #(.AW(IDX_W), .DW(CODE_W)) tbl ();

  table_mem #(.DEPTH(TBL_DEPTH), .AW(IDX_W), .DW(CODE_W)) u_table (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tbl(tbl.mem)
  );

  conv_state_t state_ff, nxt_state;
  logic signed [CODE_W-1:0] code_ff, nxt_code;
  logic signed [CODE_W-1:0] prev_ff, nxt_prev;
  logic [IDX_W-1:0] idx_ff, nxt_idx;
  logic [DIF_W-1:0] rem_ff, nxt_rem;
  logic [DIF_W-1:0] den_ff, nxt_den;
  logic [TEMP_FRAC_W-1:0] quot_ff, nxt_quot;
  logic [BIT_W-1:0] bit_ff, nxt_bit;
  logic [RES_W-1:0] res_ff, nxt_res;
  logic res_valid_ff, nxt_res_valid;
  logic temp_valid_ff, nxt_temp_valid;
  logic [IDX_W-1:0] temp_int_ff, nxt_temp_int;
  logic [TEMP_FRAC_W-1:0] temp_frac_ff, nxt_temp_frac;
  logic oor_ff, nxt_oor;
  logic gain_err_ff, nxt_gain_err;
  logic strap_taken_ff, nxt_strap_taken;
  logic [6:0] addr_ff, nxt_addr;

  logic [SHIFT_W-1:0] gain_shift;
  logic gain_bad;
  logic signed [PROD_W-1:0] prod;
  logic signed [CODE_W-1:0] entry;
  logic [DIF_W-1:0] rem_sh;

  // table is never written from inside; loads come straight from the port
  assign tbl.wr_en = tbl_wr_i;
  assign tbl.wr_addr = tbl_wr_addr_i;
  assign tbl.wr_data = tbl_wr_data_i;
  assign tbl.rd_addr = idx_ff;

  // gain code to shift; unsupported codes fall back to unity and flag
  always_comb
  begin
    gain_shift = 2'h0;
    gain_bad = 1'b0;
    case (gain_sel_i)
      GAIN_SEL_1: gain_shift = 2'h0;
      GAIN_SEL_2: gain_shift = 2'h1;
      GAIN_SEL_4: gain_shift = 2'h2;
      default: gain_bad = 1'b1;
    endcase
  end

  // m * rref * code, then divide by gain * 2^24 keeping 16 fraction bits
  assign prod = PROD_W'(signed'(code_i)) * RREF_K;
  assign entry = signed'(tbl.rd_data);
  assign rem_sh = {rem_ff[DIF_W-2:0], 1'b0};

  // conversion sequence: resistance at capture, then table scan, then divide
  always_comb
  begin
    nxt_state = state_ff;
    nxt_code = code_ff;
    nxt_prev = prev_ff;
    nxt_idx = idx_ff;
    nxt_rem = rem_ff;
    nxt_den = den_ff;
    nxt_quot = quot_ff;
    nxt_bit = bit_ff;
    nxt_res = res_ff;
    nxt_res_valid = 1'b0;
    nxt_temp_valid = 1'b0;
    nxt_temp_int = temp_int_ff;
    nxt_temp_frac = temp_frac_ff;
    nxt_oor = oor_ff;
    nxt_gain_err = gain_err_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (code_valid_i)
        begin
          nxt_code = signed'(code_i);
          nxt_gain_err = gain_bad;
          // arithmetic shift keeps negative codes negative
          nxt_res = RES_W'(prod >>> (RES_SHIFT + int'(gain_shift)));
          nxt_res_valid = 1'b1;
          nxt_idx = '0;
          if (code_i == CODE_POS_FS || code_i == CODE_NEG_FS)
            nxt_oor = 1'b1;
          else
          begin
            nxt_oor = 1'b0;
            nxt_state = ST_RD;
          end
        end
      end
      // address already on the table, data lands at this edge
      ST_RD:
        nxt_state = ST_CMP;
      ST_CMP:
      begin
        if (entry > code_ff)
        begin
          if (idx_ff == '0)
          begin
            nxt_oor = 1'b1;
            nxt_state = ST_IDLE;
          end
          else
          begin
            nxt_idx = idx_ff - 1'b1;
            nxt_rem = DIF_W'(code_ff) - DIF_W'(prev_ff);
            nxt_den = DIF_W'(entry) - DIF_W'(prev_ff);
            nxt_quot = '0;
            nxt_bit = '0;
            nxt_state = ST_DIV;
          end
        end
        // a code at or past the last entry has no n+1 to interpolate to
        else if (idx_ff == IDX_W'(TBL_DEPTH - 1))
        begin
          nxt_oor = 1'b1;
          nxt_state = ST_IDLE;
        end
        else
        begin
          nxt_prev = entry;
          nxt_idx = idx_ff + 1'b1;
          nxt_state = ST_RD;
        end
      end
      // restoring division, one fraction bit per cycle
      ST_DIV:
      begin
        if (rem_sh >= den_ff)
        begin
          nxt_rem = rem_sh - den_ff;
          nxt_quot = {quot_ff[TEMP_FRAC_W-2:0], 1'b1};
        end
        else
        begin
          nxt_rem = rem_sh;
          nxt_quot = {quot_ff[TEMP_FRAC_W-2:0], 1'b0};
        end
        nxt_bit = bit_ff + 1'b1;
        if (bit_ff == BIT_W'(TEMP_FRAC_W - 1))
        begin
          nxt_temp_int = idx_ff;
          nxt_temp_frac = nxt_quot;
          nxt_temp_valid = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // strap levels caught once, on the first edge after reset release
  always_comb
  begin
    nxt_strap_taken = 1'b1;
    nxt_addr = addr_ff;
    if (!strap_taken_ff)
      nxt_addr = TARGET_ADDR_BASE ^ {5'h0, address_strap_b_i, address_strap_a_i};
  end

  // state registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= ST_IDLE;
      code_ff <= '0;
      prev_ff <= '0;
      idx_ff <= '0;
      rem_ff <= '0;
      den_ff <= '0;
      quot_ff <= '0;
      bit_ff <= '0;
      res_ff <= '0;
      res_valid_ff <= 1'b0;
      temp_valid_ff <= 1'b0;
      temp_int_ff <= '0;
      temp_frac_ff <= '0;
      oor_ff <= 1'b0;
      gain_err_ff <= 1'b0;
      strap_taken_ff <= 1'b0;
      addr_ff <= TARGET_ADDR_BASE;
    end
    else
    begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
      prev_ff <= nxt_prev;
      idx_ff <= nxt_idx;
      rem_ff <= nxt_rem;
      den_ff <= nxt_den;
      quot_ff <= nxt_quot;
      bit_ff <= nxt_bit;
      res_ff <= nxt_res;
      res_valid_ff <= nxt_res_valid;
      temp_valid_ff <= nxt_temp_valid;
      temp_int_ff <= nxt_temp_int;
      temp_frac_ff <= nxt_temp_frac;
      oor_ff <= nxt_oor;
      gain_err_ff <= nxt_gain_err;
      strap_taken_ff <= nxt_strap_taken;
      addr_ff <= nxt_addr;
    end
  end

  // outputs
  assign code_ready_o = (state_ff == ST_IDLE);
  assign busy_o = (state_ff != ST_IDLE);
  assign res_o = res_ff;
  assign res_valid_o = res_valid_ff;
  assign temp_valid_o = temp_valid_ff;
  assign temp_int_o = temp_int_ff; // held while out of range
  assign temp_frac_o = temp_frac_ff;
  assign out_of_range_o = oor_ff;
  assign gain_err_o = gain_err_ff;
  assign target_addr_o = addr_ff;
endmodule

/* hdl/rtd_conv_pkg.sv */
// constants and types shared by the code-to-temperature datapath
package rtd_conv_pkg;
  // conversion code format
  localparam int CODE_W = 24;
  localparam logic [CODE_W-1:0] CODE_POS_FS = 24'h7fffff;
  localparam logic [CODE_W-1:0] CODE_NEG_FS = 24'h800000;
  localparam int LSB_EXP = 24;
  // full-scale scaling and reference resistor
  localparam int SCALE_M = 2;
  localparam int RREF_OHM_DFLT = 3900;
  localparam int RREF_K_W = 16;
  localparam int PROD_W = 40;
  // gain selection field and its codes
  localparam int GAIN_SEL_W = 3;
  localparam logic [GAIN_SEL_W-1:0] GAIN_SEL_1 = 3'h0;
  localparam logic [GAIN_SEL_W-1:0] GAIN_SEL_2 = 3'h1;
  localparam logic [GAIN_SEL_W-1:0] GAIN_SEL_4 = 3'h2;
  localparam int SHIFT_W = 2;
  // result formats
  localparam int RES_W = 32;
  localparam int RES_FRAC_W = 16;
  localparam int TEMP_FRAC_W = 8;
  localparam int TBL_DEPTH_DFLT = 256;
  // serial target address with both straps low
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h45;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_CMP, ST_DIV} conv_state_t;
endpackage

/* hdl/table_if.sv */
// carrier between the converter and its lookup table memory
`timescale 1ns/1ns
interface table_if #(parameter int AW = 8, parameter int DW = 24);
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  modport user (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

/* hdl/table_mem.sv */
// lookup table of conversion codes, one per degree, registered read
`timescale 1ns/1ns
module table_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter int DW = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // table port
  table_if.mem tbl
);
  logic [DW-1:0] mem_array [DEPTH];
  logic [DW-1:0] rd_data_ff;

  // storage carries no reset, contents come from the load port
  always_ff @(posedge clk_i)
  begin
    if (tbl.wr_en)
      mem_array[tbl.wr_addr] <= tbl.wr_data;
  end

  // read data registered, one cycle after the address
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rd_data_ff <= '0;
    else
      rd_data_ff <= mem_array[tbl.rd_addr];
  end

  assign tbl.rd_data = rd_data_ff;
endmodule

/* testbench/conv_props.sv */
// port-level assertion checker for the code-to-temperature datapath
`timescale 1ns/1ns
module conv_props #(
  parameter int TBL_DEPTH = 256,
  parameter int IDX_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // code stream and configuration
  input wire logic code_valid_i,
  input wire logic [23:0] code_i,
  input wire logic code_ready_o,
  input wire logic [2:0] gain_sel_i,
  input wire logic address_strap_a_i,
  input wire logic address_strap_b_i,
  // results
  input wire logic res_valid_o,
  input wire logic [31:0] res_o,
  input wire logic temp_valid_o,
  input wire logic [IDX_W-1:0] temp_int_o,
  input wire logic [7:0] temp_frac_o,
  input wire logic out_of_range_o,
  input wire logic gain_err_o,
  input wire logic busy_o,
  input wire logic [6:0] target_addr_o
);
  // worst scan: every entry read and compared, then the divide
  localparam int MAXW = 2 * TBL_DEPTH + 10;
  logic take;
  logic clip;
  assign take = code_valid_i && code_ready_o;
  assign clip = code_i == 24'h7fffff || code_i == 24'h800000;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // resistance path
  res_pulse_a: assert property (take |=> res_valid_o)
    else $error("no result pulse after a take");
  res_sign_a: assert property (take |=> res_o[31] == $past(code_i[23]))
    else $error("resistance sign differs from code sign");
  gain_err_a: assert property (take |=> gain_err_o == ($past(gain_sel_i) > 3'h2))
    else $error("gain error flag wrong");
  // range status and temperature
  clip_flag_a: assert property (take && clip |=> out_of_range_o && code_ready_o)
    else $error("clipped code not flagged");
  oor_clear_a: assert property (take && !clip |=> !out_of_range_o)
    else $error("range flag not cleared");
  temp_ok_a: assert property (temp_valid_o |-> !out_of_range_o && code_ready_o)
    else $error("temperature given while out of range");
  temp_hold_a: assert property (!temp_valid_o |-> $stable({temp_int_o, temp_frac_o}))
    else $error("temperature moved without a pulse");
  scan_time_a: assert property (take && !clip |=> busy_o ##[1:MAXW] code_ready_o)
    else $error("table scan too long");
  temp_early_a: assert property (take |=> !temp_valid_o [*8])
    else $error("temperature before scan and divide");
  addr_low_a: assert property (!address_strap_a_i && !address_strap_b_i |-> target_addr_o == 7'h45)
    else $error("target address wrong with straps low");
endmodule
bind adc_code_to_temperature conv_props #(.TBL_DEPTH(TBL_DEPTH), .IDX_W(IDX_W)) props_u (.*);

/* testbench/adc_model.sv */
// conversion source offering codes over the valid/ready handshake
`timescale 1ns/1ns
module adc_model (
  // clock
  input wire logic clk_i,
  // code stream
  input wire logic code_ready_i,
  output logic code_valid_o,
  output logic [23:0] code_o
);
  int hang = 0;
  initial
  begin
    code_valid_o = 1'b0;
    code_o = 24'h0;
  end
  // hold the code until the edge that takes it; keep lets a next code follow at once
  task automatic send(input logic [23:0] code, input int gap, input logic keep);
    int n;
    repeat (gap) @(posedge clk_i);
    if (gap > 0)
      #1;
    code_valid_o = 1'b1;
    code_o = code; // two's-complement, clipped at the extremes
    for (n = 0; n < 40 && code_ready_i !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    if (n == 40)
      hang++;
    @(posedge clk_i);
    #1;
    if (!keep)
    begin
      code_valid_o = 1'b0;
      code_o = ~code; // released bus shows no stale value
    end
  endtask
endmodule

/* testbench/tb.sv */
// self-checking bench for the code-to-temperature datapath
`timescale 1ns/1ns
module tb;
  import rtd_conv_pkg::*;
  localparam int D = 8;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] gain_sel_i = 3'h0;
  logic address_strap_a_i = 1'b0;
  logic address_strap_b_i = 1'b0;
  logic tbl_wr_i = 1'b0;
  logic [2:0] tbl_wr_addr_i = 3'h0;
  logic [23:0] tbl_wr_data_i = 24'h0;
  logic code_valid_i, code_ready_o, res_valid_o, temp_valid_o, out_of_range_o, gain_err_o, busy_o;
  logic [23:0] code_i;
  logic [31:0] res_o;
  logic [2:0] temp_int_o;
  logic [7:0] temp_frac_o;
  logic [6:0] target_addr_o;
  logic [23:0] t [D];
  logic [32:0] rq [$];
  logic [11:0] tq [$];
  int failures = 0;
  int num_checks = 0;
  integer seed = 32'he9d73c2f;
  always #50 clk_i = ~clk_i;
  adc_model adc_u (.clk_i(clk_i), .code_ready_i(code_ready_o), .code_valid_o(code_valid_i),
    .code_o(code_i));
  adc_code_to_temperature #(.TBL_DEPTH(D), .IDX_W(3)) dut_u (.*);
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // expected resistance, Q15.16, floor shift by gain
  function automatic logic [32:0] rexp(logic [23:0] c, logic [2:0] g);
    longint p;
    p = longint'(signed'(c)) * SCALE_M * RREF_OHM_DFLT;
    p = p >>> (g == GAIN_SEL_2 ? 9 : g == GAIN_SEL_4 ? 10 : 8);
    return {g > GAIN_SEL_4, p[31:0]};
  endfunction
  // watcher pairs each result pulse with the oldest note; an empty queue never matches
  always @(negedge clk_i)
  begin
    if (res_valid_o === 1'b1)
      chk({gain_err_o, res_o}, rq.size() ? rq.pop_front() : '1);
    if (temp_valid_o === 1'b1)
      chk({out_of_range_o, temp_int_o, temp_frac_o}, tq.size() ? tq.pop_front() : '1);
  end
  // note expectations, send a code, wait for idle and check the range status
  task automatic conv(input logic [23:0] c, input logic [2:0] g, input int gap, input logic keep);
    int n;
    logic hit;
    logic [10:0] held;
    held = {temp_int_o, temp_frac_o};
    hit = !c[23] && c != CODE_POS_FS && c >= t[0] && c < t[D-1];
    n = 0;
    for (int k = 1; k < D; k++)
      if (t[k] <= c)
        n = k;
    gain_sel_i = g;
    rq.push_back(rexp(c, g));
    if (hit)
      tq.push_back({1'b0, 3'(n), 8'((c - t[n]) * 256 / (t[n+1] - t[n]))});
    adc_u.send(c, gap, keep);
    for (n = 0; n < 40 && code_ready_o !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    if (n == 40 || adc_u.hang != 0)
    begin
      failures++;
      finish_test();
    end
    chk(out_of_range_o, !hit);
    if (!hit)
      chk({temp_int_o, temp_frac_o}, held);
  endtask
  task automatic rst(input logic [1:0] s);
    rstn_i = 1'b0;
    {address_strap_b_i, address_strap_a_i} = s;
    repeat (16) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    @(posedge clk_i);
    #1;
    chk(target_addr_o, TARGET_ADDR_BASE ^ {5'h0, s});
  endtask
  initial
  begin
    rst(2'h0);
    // strictly increasing table with uneven steps
    for (int i = 0; i < D; i++)
    begin
      t[i] = 24'(1000 + i * 300 + i * i * 7);
      tbl_wr_i = 1'b1;
      tbl_wr_addr_i = 3'(i);
      tbl_wr_data_i = t[i];
      @(posedge clk_i);
      #1;
    end
    tbl_wr_i = 1'b0;
    for (int i = 0; i < 8; i++)
      conv(t[1] + 24'(i * 37), 3'(i), 1 + i % 3, 1'b0);
    for (int i = 0; i < D; i++)
      conv(t[i], 3'h0, 1, 1'b0);
    for (int i = 0; i < 24; i++)
      conv(t[0] - 24'd50 + 24'($unsigned($random(seed)) % 2600),
        3'($unsigned($random(seed)) % 3), 1 + $unsigned($random(seed)) % 3, 1'b0);
    conv(CODE_POS_FS, 3'h1, 1, 1'b1);
    conv(CODE_NEG_FS, 3'h2, 0, 1'b0);
    conv(24'hfffc18, 3'h0, 1, 1'b0);
    // mid-run resets with each strap alone; the table has no reset, so convert at once
    rst(2'h2);
    rst(2'h1);
    conv(t[2] + 24'd77, 3'h2, 0, 1'b0);
    repeat (20) @(posedge clk_i);
    #1;
    chk(rq.size() + tq.size(), 0);
    finish_test();
  end
endmodule
